// ==== hdl/ovs_supervisor.sv ====
// output voltage supervisor: power good, ov protection, telemetry and duty limit
// What this block does
// [R1] reports the sensed output voltage in counts of 1/256 V.
// [R2] flags ov warning, uv fault and uv warning against their own programmed limits.
// [R3] in programmed mode power good is high while the sense voltage is inside the window, low otherwise.
// [R4] the window has separate rising (on) and falling (off) limits.
// [R5] a power good limit more than 630 mV below vout is replaced by vout - 630 mV.
// [R6] power good asserts at once by default, or after 0 to 10 ms in 1 ms steps.
// [R7] in serial mode power good follows the tolerance band around the boot voltage.
// [R8] in serial mode power good holds through transitions, dropping on fault or 0 V.
// [R9] the ov trip asserts 200 ns after the sense voltage rises over the threshold.
// [R10] by default an ov trip latches the high side off and drops power good.
// [R11] during a default ov fault the low side stays on until sense falls below the limit.
// [R12] the high side latch holds until enable or the operation command is cycled.
// [R13] with ov set to ignore, conversion goes on but status and alert still record it.
// [R14] an ov limit more than 655 mV above vout is replaced by vout + 655 mV.
// [R15] ov detection works in both programmed and serial mode.
// [R16] each period is blanked for the larger of a fixed off time or one eighth period.
// [R17] the power good delay restarts from zero whenever sense leaves the window early.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ovs_regs.svh"
`default_nettype none
module ovs_supervisor #(
  parameter int VW          = 16,
  parameter int PG_STEP_CYC = `OVS_PG_STEP_US * `OVS_CLK_MHZ,
  parameter int PER_W       = 12,
  parameter int OFF_MIN     = 20
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // sense samples and comparator (pins)
  input  wire logic [VW-1:0]    sense_sample,
  input  wire logic             ov_comp_pin,
  input  wire logic             enable_pin,
  input  wire logic             conv_fault,
  // switching period
  input  wire logic [PER_W-1:0] period_cycles,
  input  wire logic             pwm_request,
  // power stage and status pins
  output logic                  high_side_drive,
  output logic                  low_side_force,
  output logic                  power_good_output_o,
  output logic                  power_good_output_oe,
  output logic                  ov_trip,
  output logic                  alert_output,
  output logic                  irq
);
  localparam int OV_DLY_CYC = (`OVS_OV_TRIP_NS * `OVS_CLK_MHZ) / 1000;
  localparam logic [VW-1:0] PG_OFS = VW'((`OVS_PG_OFS_MV * `OVS_LSB_PER_V) / 1000);
  localparam logic [VW-1:0] OV_OFS = VW'((`OVS_OV_OFS_MV * `OVS_LSB_PER_V) / 1000);
  localparam int PG_CW = $clog2(PG_STEP_CYC + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamp a limit into vout +/- ofs
  function automatic logic [VW-1:0] clamp_hi(input logic [VW-1:0] lim,
                                             input logic [VW-1:0] v,
                                             input logic [VW-1:0] ofs);
    logic [VW:0] top;
    top = {1'b0, v} + {1'b0, ofs};
    clamp_hi = ({1'b0, lim} > top) ? top[VW-1:0] : lim;
  endfunction
  function automatic logic [VW-1:0] clamp_lo(input logic [VW-1:0] lim,
                                             input logic [VW-1:0] v,
                                             input logic [VW-1:0] ofs);
    logic [VW-1:0] bot;
    bot = (v > ofs) ? v - ofs : '0;
    clamp_lo = (lim < bot) ? bot : lim;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [VW-1:0] samp_m, samp;
  logic [2:0]    pin_m, pin_s;
  // two flops for the sense sample and the ov, enable and fault pins
  always_ff @(posedge clock) begin
    if (srst) begin
      samp_m <= '0;
      samp   <= '0;
      pin_m  <= 3'h0;
      pin_s  <= 3'h0;
    end else begin
      samp_m <= sense_sample;
      samp   <= samp_m;
      pin_m  <= {conv_fault, enable_pin, ov_comp_pin};
      pin_s  <= pin_m;
    end
  end
  wire ov_cmp = pin_s[0];
  wire en_s   = pin_s[1];
  wire flt_s  = pin_s[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0]          ctrl;
  logic [VW-1:0]       vset, pg_on, pg_off, ov_lim, ov_warn, uv_lim, uv_warn, boot, tol;
  logic [3:0]          pg_dly;
  logic [`OVS_ST_W-1:0] status, mask, ev;
  wire wr = psel && penable && pwrite;
  // software writes
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl    <= `OVS_CTRL_RST;
      vset    <= `OVS_VSET_RST;
      pg_on   <= `OVS_PG_ON_RST;
      pg_off  <= `OVS_PG_OFF_RST;
      ov_lim  <= `OVS_OV_FAULT_RST;
      ov_warn <= `OVS_OV_WARN_RST;
      uv_lim  <= `OVS_UV_FAULT_RST;
      uv_warn <= `OVS_UV_WARN_RST;
      boot    <= `OVS_BOOT_RST;
      tol     <= `OVS_BOOT_TOL_RST;
      pg_dly  <= 4'h0;
      mask    <= '0;
    end else if (wr) begin
      case (paddr)
        `OVS_CTRL_OFF:     ctrl    <= pwdata[3:0];
        `OVS_MASK_OFF:     mask    <= pwdata[`OVS_ST_W-1:0];
        `OVS_VSET_OFF:     vset    <= pwdata[VW-1:0];
        `OVS_PG_ON_OFF:    pg_on   <= pwdata[VW-1:0];
        `OVS_PG_OFF_OFF:   pg_off  <= pwdata[VW-1:0];
        `OVS_OV_FAULT_OFF: ov_lim  <= pwdata[VW-1:0];
        `OVS_OV_WARN_OFF:  ov_warn <= pwdata[VW-1:0];
        `OVS_UV_FAULT_OFF: uv_lim  <= pwdata[VW-1:0];
        `OVS_UV_WARN_OFF:  uv_warn <= pwdata[VW-1:0];
        `OVS_PG_DLY_OFF:   pg_dly  <= (pwdata[3:0] > `OVS_PG_DLY_MAX) ?
                                      `OVS_PG_DLY_MAX : pwdata[3:0]; // R6
        `OVS_BOOT_OFF: begin
          boot <= pwdata[VW-1:0];
          tol  <= pwdata[16+VW-1:16];
        end
        default: ;
      endcase
    end
  end
  wire run     = ctrl[`OVS_CTRL_ENABLE] && en_s;
  wire serial  = ctrl[`OVS_CTRL_SERIAL];
  wire ov_ign  = ctrl[`OVS_CTRL_OV_IGN];

  // ----------------------------------------------------------------
  // effective thresholds and digital comparisons
  // ----------------------------------------------------------------
  logic [VW-1:0] on_eff, off_eff, ov_eff;
  always_comb begin
    on_eff  = clamp_lo(pg_on, vset, PG_OFS);  // R5
    off_eff = clamp_lo(pg_off, vset, PG_OFS); // R5
    ov_eff  = clamp_hi(ov_lim, vset, OV_OFS); // R14
  end
  // R2 digitized limit checks
  wire ov_w  = samp > ov_warn;
  wire uv_f  = samp < uv_lim;
  wire uv_w  = samp < uv_warn;
  // analog comparator or digital sample over the effective limit, any mode R15
  wire ov_raw = ov_cmp || (samp > ov_eff);

  // ----------------------------------------------------------------
  // ov trip filter: 200 ns of continuous overvoltage
  // ----------------------------------------------------------------
  logic [7:0] ov_cnt;
  always_ff @(posedge clock) begin
    if (srst || !ov_raw) begin
      ov_cnt  <= 8'h00;
      ov_trip <= 1'b0;
    end else if (ov_cnt < 8'(OV_DLY_CYC)) begin
      ov_cnt <= ov_cnt + 8'h01;
    end else begin
      ov_trip <= 1'b1; // R9
    end
  end

  // ----------------------------------------------------------------
  // ov fault response state machine
  // ----------------------------------------------------------------
  ovs_pkg::ovs_ov_state_t st;
  always_ff @(posedge clock) begin
    if (srst) begin
      st <= ovs_pkg::OVS_RUN;
    end else begin
      case (st)
        ovs_pkg::OVS_RUN:
          if (ov_trip && !ov_ign) begin
            st <= ovs_pkg::OVS_TRIP; // R10
          end
        ovs_pkg::OVS_TRIP:
          if (!ov_raw) begin
            st <= ovs_pkg::OVS_LATCH; // R11
          end
        ovs_pkg::OVS_LATCH:
          if (!run) begin
            st <= ovs_pkg::OVS_RUN; // R12
          end else if (ov_trip) begin
            st <= ovs_pkg::OVS_TRIP;
          end
        default: st <= ovs_pkg::OVS_RUN;
      endcase
    end
  end
  wire ov_latched = (st != ovs_pkg::OVS_RUN);

  // ----------------------------------------------------------------
  // duty limit: blank for max(fixed off, period/8)
  // ----------------------------------------------------------------
  logic [PER_W-1:0] pcnt;
  logic [PER_W-1:0] blank;
  always_comb begin
    blank = period_cycles / PER_W'(`OVS_DUTY_DIV);
    if (blank < PER_W'(OFF_MIN)) begin
      blank = PER_W'(OFF_MIN); // R16
    end
  end
  always_ff @(posedge clock) begin
    if (srst || pcnt + PER_W'(1) >= period_cycles) begin
      pcnt <= '0;
    end else begin
      pcnt <= pcnt + PER_W'(1);
    end
  end
  wire in_blank = pcnt < blank; // R16

  // gate drives
  always_ff @(posedge clock) begin
    if (srst) begin
      high_side_drive <= 1'b0;
      low_side_force  <= 1'b0;
    end else begin
      high_side_drive <= run && !ov_latched && !flt_s && pwm_request && !in_blank; // R10 R13
      low_side_force  <= (st == ovs_pkg::OVS_TRIP); // R11
    end
  end

  // ----------------------------------------------------------------
  // power good window and delay
  // ----------------------------------------------------------------
  logic             win;
  logic [PG_CW-1:0] step;
  logic [3:0]       ms;
  logic             pg, ser_pg;
  // hysteretic window, on rising limit when low, off falling limit when high
  wire in_win = pg ? (samp >= off_eff && !ov_raw) : (samp >= on_eff && !ov_raw); // R3 R4
  wire in_tol = ({1'b0, samp} + {1'b0, tol} >= {1'b0, boot}) &&
                ({1'b0, samp} <= {1'b0, boot} + {1'b0, tol}); // R7
  wire zero_cmd = ctrl[`OVS_CTRL_ZERO_PG] && (vset == '0);
  always_ff @(posedge clock) begin
    if (srst || !serial || !run || flt_s || ov_latched) begin
      ser_pg <= 1'b0; // R8
    end else if (zero_cmd) begin
      ser_pg <= 1'b0; // R8
    end else if (in_tol) begin
      ser_pg <= 1'b1; // R7
    end
  end
  always_ff @(posedge clock) begin
    if (srst || !in_win || !run) begin
      step <= '0; // R17
      ms   <= 4'h0;
      win  <= 1'b0;
    end else if (ms >= pg_dly) begin
      win <= 1'b1; // R6
    end else if (step == PG_CW'(PG_STEP_CYC - 1)) begin
      step <= '0;
      ms   <= ms + 4'h1;
    end else begin
      step <= step + PG_CW'(1);
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      pg <= 1'b0;
    end else if (ov_latched) begin
      pg <= 1'b0; // R10
    end else if (serial) begin
      pg <= ser_pg; // R7 R8
    end else begin
      pg <= win && in_win; // R3
    end
  end
  // open drain: drive low while not good
  always_ff @(posedge clock) begin
    if (srst) begin
      power_good_output_o  <= 1'b0;
      power_good_output_oe <= 1'b1;
    end else begin
      power_good_output_o  <= 1'b0;
      power_good_output_oe <= !pg; // R3
    end
  end

  // ----------------------------------------------------------------
  // status, interrupt, alert
  // ----------------------------------------------------------------
  logic pg_d;
  always_ff @(posedge clock) begin
    if (srst) begin
      pg_d <= 1'b0;
    end else begin
      pg_d <= pg;
    end
  end
  always_comb begin
    ev = '0;
    ev[`OVS_ST_OV_FAULT] = ov_trip; // R13
    ev[`OVS_ST_OV_WARN]  = ov_w;    // R2
    ev[`OVS_ST_UV_FAULT] = uv_f && run;
    ev[`OVS_ST_UV_WARN]  = uv_w && run;
    ev[`OVS_ST_PG_FALL]  = pg_d && !pg;
  end
  // set wins over write-one-to-clear
  always_ff @(posedge clock) begin
    if (srst) begin
      status <= '0;
    end else if (wr && paddr == `OVS_STATUS_OFF) begin
      status <= (status & ~pwdata[`OVS_ST_W-1:0]) | ev;
    end else begin
      status <= status | ev;
    end
  end
  // a set mask bit hides its status bit from irq, and from alert except the ov fault bit
  always_ff @(posedge clock) begin
    if (srst) begin
      irq          <= 1'b0;
      alert_output <= 1'b0;
    end else begin
      irq          <= |(status & ~mask);
      alert_output <= |(status & ~mask) || status[`OVS_ST_OV_FAULT]; // R13
    end
  end

  // ----------------------------------------------------------------
  // apb read side, zero wait
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `OVS_CTRL_OFF:     prdata <= {28'h0, ctrl};
          `OVS_STATUS_OFF:   prdata <= {27'h0, status};
          `OVS_MASK_OFF:     prdata <= {27'h0, mask};
          `OVS_VOUT_OFF:     prdata <= {16'h0, samp}; // R1
          `OVS_VSET_OFF:     prdata <= {16'h0, vset};
          `OVS_PG_ON_OFF:    prdata <= {16'h0, pg_on};
          `OVS_PG_OFF_OFF:   prdata <= {16'h0, pg_off};
          `OVS_OV_FAULT_OFF: prdata <= {16'h0, ov_lim};
          `OVS_OV_WARN_OFF:  prdata <= {16'h0, ov_warn};
          `OVS_UV_FAULT_OFF: prdata <= {16'h0, uv_lim};
          `OVS_UV_WARN_OFF:  prdata <= {16'h0, uv_warn};
          `OVS_PG_DLY_OFF:   prdata <= {28'h0, pg_dly};
          `OVS_BOOT_OFF:     prdata <= {tol, boot};
          `OVS_STATE_OFF:    prdata <= {26'h0, ov_trip, ov_latched, st, pg};
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ov_latch_hs: assert property (@(posedge clock) disable iff (srst) // R10
    ov_latched |=> !high_side_drive) else $error("high side on while ov latched");
  a_ov_pg_low: assert property (@(posedge clock) disable iff (srst) // R10
    ov_latched |=> !pg) else $error("power good high during ov latch");
  a_ov_ls_on: assert property (@(posedge clock) disable iff (srst) // R11
    (st == ovs_pkg::OVS_TRIP) |=> low_side_force) else $error("low side off in ov trip");
  a_ov_trip_dly: assert property (@(posedge clock) disable iff (srst) // R9
    $rose(ov_trip) |-> $past(ov_raw, OV_DLY_CYC)) else $error("ov trip too early");
  a_ov_ignore: assert property (@(posedge clock) disable iff (srst) // R13
    (ov_ign && st == ovs_pkg::OVS_RUN && ov_trip) |=> status[`OVS_ST_OV_FAULT] && !ov_latched)
    else $error("ignored ov not recorded");
  a_pg_window: assert property (@(posedge clock) disable iff (srst) // R3
    (!serial && !in_win) |=> !pg) else $error("power good outside window");
  a_pg_restart: assert property (@(posedge clock) disable iff (srst) // R17
    !in_win |=> (ms == 4'h0 && step == '0)) else $error("delay not restarted");
  a_blank_hs: assert property (@(posedge clock) disable iff (srst) // R16
    in_blank |=> !high_side_drive) else $error("high side during blanking");
endmodule
`default_nettype wire

// ==== hdl/ovs_regs.svh ====
// register offsets, field positions, reset values and timing counts of the supervisor
`ifndef OVS_REGS_SVH
`define OVS_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OVS_CTRL_OFF      12'h000
`define OVS_STATUS_OFF    12'h004
`define OVS_MASK_OFF      12'h008
`define OVS_VOUT_OFF      12'h00c
`define OVS_VSET_OFF      12'h010
`define OVS_PG_ON_OFF     12'h014
`define OVS_PG_OFF_OFF    12'h018
`define OVS_OV_FAULT_OFF  12'h01c
`define OVS_OV_WARN_OFF   12'h020
`define OVS_UV_FAULT_OFF  12'h024
`define OVS_UV_WARN_OFF   12'h028
`define OVS_PG_DLY_OFF    12'h02c
`define OVS_BOOT_OFF      12'h030
`define OVS_STATE_OFF     12'h034
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define OVS_CTRL_ENABLE   0
`define OVS_CTRL_SERIAL   1
`define OVS_CTRL_OV_IGN   2
`define OVS_CTRL_ZERO_PG  3
// ----------------------------------------------------------------
// status / mask fields
// ----------------------------------------------------------------
`define OVS_ST_OV_FAULT   0
`define OVS_ST_OV_WARN    1
`define OVS_ST_UV_FAULT   2
`define OVS_ST_UV_WARN    3
`define OVS_ST_PG_FALL    4
`define OVS_ST_W          5
// ----------------------------------------------------------------
// reset values (voltages in 1/256 V counts)
// ----------------------------------------------------------------
`define OVS_CTRL_RST      4'h1
`define OVS_VSET_RST      16'h0100
`define OVS_PG_ON_RST     16'h00e6
`define OVS_PG_OFF_RST    16'h00d9
`define OVS_OV_FAULT_RST  16'h0133
`define OVS_OV_WARN_RST   16'h0126
`define OVS_UV_FAULT_RST  16'h00cc
`define OVS_UV_WARN_RST   16'h00d9
`define OVS_BOOT_RST      16'h0100
`define OVS_BOOT_TOL_RST  16'h000d
// ----------------------------------------------------------------
// timing and offsets
// ----------------------------------------------------------------
`define OVS_CLK_MHZ       250
`define OVS_OV_TRIP_NS    200
`define OVS_PG_STEP_US    1000
`define OVS_PG_DLY_MAX    4'ha
`define OVS_PG_OFS_MV     630
`define OVS_OV_OFS_MV     655
`define OVS_DUTY_DIV      8
`define OVS_LSB_PER_V     256
`endif

// ==== hdl/ovs_pkg.sv ====
// types shared by the output supervisor
package ovs_pkg;
  typedef enum logic [2:0] {
    OVS_RUN   = 3'b001,
    OVS_TRIP  = 3'b010,
    OVS_LATCH = 3'b100
  } ovs_ov_state_t;
endpackage

// ==== verification/ovs_pg_monitor.sv ====
// system side of the open-drain power good line, with its pull-up
`timescale 1ns/1ps
`default_nettype none
module ovs_pg_monitor (
  // open-drain pin from the supervisor
  input  wire logic pg_o,
  input  wire logic pg_oe,
  // level seen by the system logic
  output logic      pg_level
);
  // the pull-up wins whenever the pin is released
  assign pg_level = pg_oe ? pg_o : 1'b1;
endmodule
`default_nettype wire

// ==== verification/test_output_supervision_power_good_ovp.sv ====
// self-checking bench of the output voltage supervisor
`timescale 1ns/1ps
`include "ovs_regs.svh"
`default_nettype none
module test_output_supervision_power_good_ovp;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam int STEP = 10;
  localparam logic [5:0] OV = 6'h20, LS = 6'h08, PG = 6'h04, AL = 6'h02, IQ = 6'h01;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr, probe;
  logic        ov_comp_pin, enable_pin, conv_fault, pwm_request, pg_o, pg_oe, pg_level;
  logic        high_side_drive, low_side_force, ov_trip, alert_output, irq;
  logic [11:0] paddr, period_cycles, ra[11];
  logic [31:0] pwdata, prdata, rv[11], md[2];
  logic [15:0] s;
  logic [15:0] sense_sample;
  logic [5:0]  pins, pq_e[$], pq_m[$];
  logic [32:0] rq_e[$], rq_m[$];
  int          failures, checks, run;
  assign pins = {ov_trip, high_side_drive, low_side_force, pg_level, alert_output, irq};
  // supervisor with a short delay step, and the system side of power good
  ovs_supervisor #(.PG_STEP_CYC(STEP)) ovs_supervisor_inst (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sense_sample(sense_sample), .ov_comp_pin(ov_comp_pin), .enable_pin(enable_pin),
    .conv_fault(conv_fault), .period_cycles(period_cycles), .pwm_request(pwm_request),
    .high_side_drive(high_side_drive), .low_side_force(low_side_force),
    .power_good_output_o(pg_o), .power_good_output_oe(pg_oe), .ov_trip(ov_trip),
    .alert_output(alert_output), .irq(irq));
  ovs_pg_monitor ovs_pg_monitor_inst (.pg_o(pg_o), .pg_oe(pg_oe), .pg_level(pg_level));
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // read answers compared with the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rq_e.size() > 0) begin
      checks++;
      if ((({pslverr, prdata} ^ rq_e[0]) & rq_m[0]) !== 33'h0) begin
        bad($sformatf("read %h expected %h", {pslverr, prdata}, rq_e[0]));
      end
      void'(rq_e.pop_front());
      void'(rq_m.pop_front());
    end
  end
  // pin samples compared with the oldest note
  always @(posedge clock) begin
    if (probe && pq_e.size() > 0) begin
      checks++;
      if (((pins ^ pq_e[0]) & pq_m[0]) !== 6'h0) begin
        bad($sformatf("pins %b expected %b", pins, pq_e[0]));
      end
      void'(pq_e.pop_front());
      void'(pq_m.pop_front());
    end
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic bad(input string m);
    failures++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad("apb timeout");
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    rq_e.push_back(e);
    rq_m.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // note a pin expectation and sample it two edges later
  task automatic pin(input logic [5:0] m, input logic [5:0] e);
    pq_e.push_back(e);
    pq_m.push_back(m);
    @(posedge clock);
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask
  task automatic sv(input logic [15:0] v);
    sense_sample <= v;
    tick(6);
  endtask
  task automatic sp(input logic [15:0] v, input logic [5:0] m, input logic [5:0] e);
    sv(v);
    pin(m, e);
  endtask
  task automatic wait_pin(input logic [5:0] m, input logic [5:0] e, input int n);
    int i;
    checks++;
    for (i = 0; i < n; i++) begin
      @(posedge clock);
      if ((pins & m) === e) break;
    end
    if (i == n) begin
      bad("pin wait timeout");
      end_sim();
    end
  endtask
  // longest unbroken high-side on time seen over n cycles
  task automatic maxrun(input int n);
    int cur;
    cur = 0;
    run = 0;
    repeat (n) begin
      @(posedge clock);
      cur = (high_side_drive === 1'b1) ? cur + 1 : 0;
      if (cur > run) run = cur;
    end
  endtask
  task automatic cmp(input bit ok, input string m);
    checks++;
    if (!ok) bad(m);
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, probe, ov_comp_pin, conv_fault} = 6'h0;
    {enable_pin, pwm_request, srst} = 3'b111;
    paddr = 12'h0;
    pwdata = 32'h0;
    sense_sample = 16'h0100;
    period_cycles = 12'h064;
    failures = 0;
    checks = 0;
    md = '{32'h1, 32'h3};
    ra = '{`OVS_CTRL_OFF, `OVS_VSET_OFF, `OVS_PG_ON_OFF, `OVS_PG_OFF_OFF, `OVS_OV_FAULT_OFF,
           `OVS_OV_WARN_OFF, `OVS_UV_FAULT_OFF, `OVS_UV_WARN_OFF, `OVS_PG_DLY_OFF,
           `OVS_BOOT_OFF, `OVS_STATUS_OFF};
    rv = '{{28'h0, `OVS_CTRL_RST}, {16'h0, `OVS_VSET_RST}, {16'h0, `OVS_PG_ON_RST},
           {16'h0, `OVS_PG_OFF_RST}, {16'h0, `OVS_OV_FAULT_RST}, {16'h0, `OVS_OV_WARN_RST},
           {16'h0, `OVS_UV_FAULT_RST}, {16'h0, `OVS_UV_WARN_RST}, 32'h0,
           {`OVS_BOOT_TOL_RST, `OVS_BOOT_RST}, 32'h0};
    s = 16'($urandom(32'hc44260d1));
    tick(12);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++) rd(ra[i], {1'b0, rv[i]}, '1);
    rd(12'h038, 33'h100000000, '1);
    wr(`OVS_VOUT_OFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      s = 16'h00e8 + 16'($urandom % 48);
      sp(s, PG, PG);
      rd(`OVS_VOUT_OFF, {17'h0, s}, '1);
    end
    sp(16'h00e0, PG, PG);
    sp(16'h00c0, PG, 6'h0);
    sp(16'h00e0, PG, 6'h0);
    sp(16'h00f0, PG, PG);
    sv(16'h0130);
    sv(16'h0100);
    rd(`OVS_STATUS_OFF, 33'h1e, '1);
    wr(`OVS_MASK_OFF, 32'h1f);
    pin(IQ, 6'h0);
    wr(`OVS_MASK_OFF, 32'h0);
    pin(IQ, IQ);
    wr(`OVS_STATUS_OFF, 32'h1f);
    rd(`OVS_STATUS_OFF, 33'h0, '1);
    pin(IQ, 6'h0);
    // delay cap, then a window exit before the delay runs out
    wr(`OVS_PG_DLY_OFF, 32'hf);
    rd(`OVS_PG_DLY_OFF, {29'h0, `OVS_PG_DLY_MAX}, '1);
    wr(`OVS_PG_DLY_OFF, 32'h2);
    sp(16'h00c0, PG, 6'h0);
    sp(16'h0100, PG, 6'h0);
    tick(4);
    sv(16'h00c0);
    sp(16'h0100, PG, 6'h0);
    tick(8);
    pin(PG, 6'h0);
    wait_pin(PG, PG, 20);
    wr(`OVS_PG_DLY_OFF, 32'h0);
    // limits far below vout fall back to the tracking offset
    wr(`OVS_PG_ON_OFF, 32'h0);
    wr(`OVS_PG_OFF_OFF, 32'h0);
    sp(16'h0050, PG, 6'h0);
    sp(16'h0070, PG, PG);
    wr(`OVS_PG_ON_OFF, {16'h0, `OVS_PG_ON_RST});
    wr(`OVS_PG_OFF_OFF, {16'h0, `OVS_PG_OFF_RST});
    // serial mode: boot band, hold through transitions, drop on fault
    sp(16'h00c0, PG, 6'h0);
    wr(`OVS_CTRL_OFF, 32'h3);
    sp(16'h00e8, PG, 6'h0);
    sp(16'h0100, PG, PG);
    sp(16'h0080, PG, PG);
    conv_fault <= 1'b1;
    tick(6);
    pin(PG, 6'h0);
    conv_fault <= 1'b0;
    // reacquire the boot band, then a command to 0 V drops power good
    sp(16'h0100, PG, PG);
    sv(16'h0080);
    wr(`OVS_CTRL_OFF, 32'hb);
    wr(`OVS_VSET_OFF, 32'h0);
    tick(3);
    pin(PG, 6'h0);
    wr(`OVS_VSET_OFF, 32'h100);
    wr(`OVS_CTRL_OFF, 32'h1);
    sv(16'h0100);
    // duty limit: fixed off time, then one eighth of a long period
    maxrun(300);
    cmp(run >= 75 && run <= 80, "on time at short period");
    period_cycles <= 12'h190;
    maxrun(900);
    cmp(run >= 345 && run <= 350, "on time at long period");
    period_cycles <= 12'h064;
    // default ov response in programmed and serial mode
    foreach (md[k]) begin
      wr(`OVS_CTRL_OFF, md[k]);
      sv(16'h0100);
      ov_comp_pin <= 1'b1;
      tick(40);
      pin(OV, 6'h0);
      wait_pin(OV, OV, 30);
      tick(2);
      pin(LS | PG | AL, LS | AL);
      maxrun(100);
      cmp(run == 0, "high side on during trip");
      ov_comp_pin <= 1'b0;
      tick(6);
      pin(LS, 6'h0);
      maxrun(200);
      cmp(run == 0, "latch released early");
      rd(`OVS_STATUS_OFF, 33'h1, 33'h1);
      enable_pin <= 1'b0;
      tick(5);
      enable_pin <= 1'b1;
      wr(`OVS_STATUS_OFF, 32'h1f);
      maxrun(300);
      cmp(run > 0, "no restart after enable cycle");
    end
    // ignore response keeps converting but still flags
    wr(`OVS_CTRL_OFF, 32'h5);
    ov_comp_pin <= 1'b1;
    wait_pin(OV | AL, OV | AL, 70);
    maxrun(200);
    cmp(run > 0, "conversion stopped under ignore");
    rd(`OVS_STATUS_OFF, 33'h1, 33'h1);
    ov_comp_pin <= 1'b0;
    tick(4);
    end_sim();
  end
endmodule
`default_nettype wire
